// [hw/srt_tuning.v]
// Purpose: per-channel rise-parameter tuning sequencer, four channels
// Assumes: one clock, the loop-side measurements arrive as pins and are synchronised
// Notes: the PID and gradient maths are outside; only their outcomes drive this block
//        outcome pins are levels held for at least three clocks so the sync sees them
`timescale 1ns/1ps
`include "srt_defs.vh"

////////////////////////////////////////////////////////////////////////
// Two-flop synchroniser; the first stage feeds nothing but the second,
// so a metastable first stage never reaches the sequencer logic
module srt_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Data
    input wire [W-1:0] d,
    output reg [W-1:0] q_reg
);
    reg [W-1:0] meta_reg;
    always @(posedge clk) begin
        if (rst) begin
            meta_reg <= {W{1'b0}};
            q_reg <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end
endmodule

module srt_tuning #(
    parameter [35:0] STABLE_CYC = `SRT_STABLE_CYC
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [3:0] addr,
    input wire [15:0] wdata,
    input wire wr,
    input wire rd,
    output reg [15:0] rdata,
    // Host lines
    input wire mode_request_line,
    input wire [3:0] tuning_request_lines,
    output reg mode_status_line,
    output reg [3:0] tuning_active_lines,
    // Loop measurement pins, per channel
    input wire [3:0] pid_nonzero,
    input wire [3:0] process_value_in_range,
    input wire [3:0] process_value_stable,
    input wire [3:0] output_limit_zero,
    input wire [3:0] tune_done,
    input wire [3:0] calc_fail,
    input wire [3:0] self_start_ok,
    input wire [3:0] self_start_bad,
    input wire [3:0] self_abort,
    // Results
    output reg [3:0] pid_control,
    output reg [3:0] rise_store,
    output reg irq
);
    localparam ST_IDLE = 2'd0;
    localparam ST_AT = 2'd1;
    localparam ST_SELF = 2'd2;

    ////////////////////////////////////////////////////////////////////////
    // Host lines and loop pins come from other domains: two flops each before use
    wire [4:0] host_raw = {mode_request_line, tuning_request_lines};
    wire [4:0] host_sync;
    wire [35:0] loop_raw = {pid_nonzero, process_value_in_range, process_value_stable,
        output_limit_zero, tune_done, calc_fail, self_start_ok, self_start_bad, self_abort};
    wire [35:0] loop_sync;
    srt_sync2 #(
        .W(5)
    ) u_sync_host (
        .clk(clk),
        .rst(rst),
        .d(host_raw),
        .q_reg(host_sync)
    );
    srt_sync2 #(
        .W(36)
    ) u_sync_loop (
        .clk(clk),
        .rst(rst),
        .d(loop_raw),
        .q_reg(loop_sync)
    );
    wire s_mode = host_sync[4];
    wire [3:0] s_req = host_sync[3:0];
    wire [3:0] s_pid = loop_sync[35:32];
    wire [3:0] s_rng = loop_sync[31:28];
    wire [3:0] s_stb = loop_sync[27:24];
    wire [3:0] s_lim = loop_sync[23:20];
    wire [3:0] s_done = loop_sync[19:16];
    wire [3:0] s_fail = loop_sync[15:12];
    wire [3:0] s_sok = loop_sync[11:8];
    wire [3:0] s_sbad = loop_sync[7:4];
    wire [3:0] s_sab = loop_sync[3:0];

    ////////////////////////////////////////////////////////////////////////
    // Mode line edge: setting mode to operation mode
    // The status line only reports operation once the synchronised request is seen
    reg mode_d_reg;
    reg [3:0] req_d_reg;
    wire mode_rise = s_mode & ~mode_d_reg;
    wire [3:0] req_rise = s_req & ~req_d_reg;
    always @(posedge clk) begin
        if (rst) begin
            mode_d_reg <= 1'b0;
            req_d_reg <= 4'h0;
            mode_status_line <= 1'b0;
        end else begin
            mode_d_reg <= s_mode;
            req_d_reg <= s_req;
            mode_status_line <= s_mode;
        end
    end

    // Stable-for-two-minutes counters, one per channel
    // 120 s at 200 MHz needs 35 bits; the counter saturates instead of wrapping,
    // so a long quiet spell never makes the value look unstable again
    reg [3:0] stable_ok_reg;
    reg [35:0] stab_cnt [0:3];

    ////////////////////////////////////////////////////////////////////////
    // Per-channel registers
    // Every channel has its own sequencer, flags and settings; only the mode line and its edge mode_rise are shared
    // Status bit 1 merges the auto-tuning error and the self-tuning completion,
    // so software reading a channel word sees both outcomes in one place
    reg [15:0] mode_sel_reg [0:3];
    reg [15:0] self_set_reg [0:3];
    reg [2:0] tstat_reg [0:3];
    reg [1:0] sstat_reg [0:3];
    reg [1:0] sstat_hi_reg [0:3];
    reg [1:0] state_reg [0:3];
    reg [3:0] armed_reg;
    reg [3:0] rise_ok_reg;
    reg [3:0] self_have_reg;
    reg [3:0] ev_reg;
    reg [3:0] irq_stat_reg;
    reg [3:0] irq_mask_reg;
    wire irq_clr = wr && addr == `SRT_OFF_IRQ_STAT;
    integer i;

    always @(posedge clk) begin
        if (rst) begin
            armed_reg <= 4'h0;
            rise_ok_reg <= 4'h0;
            self_have_reg <= 4'h0;
            ev_reg <= 4'h0;
            tuning_active_lines <= 4'h0;
            pid_control <= 4'hf;
            rise_store <= 4'h0;
            stable_ok_reg <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                mode_sel_reg[i] <= 16'h0;
                self_set_reg[i] <= 16'h0;
                tstat_reg[i] <= 3'h0;
                sstat_reg[i] <= 2'h0;
                sstat_hi_reg[i] <= 2'h0;
                state_reg[i] <= ST_IDLE;
                stab_cnt[i] <= 36'h0;
            end
        end else begin
            ev_reg <= 4'h0;
            rise_store <= 4'h0;
            for (i = 0; i < 4; i = i + 1) begin
                if (!s_stb[i])
                    stab_cnt[i] <= 36'h0;
                else if (stab_cnt[i] < STABLE_CYC)
                    stab_cnt[i] <= stab_cnt[i] + 36'h1;
                stable_ok_reg[i] <= s_stb[i] && stab_cnt[i] >= STABLE_CYC - 1;
                if (wr && !mode_status_line && addr == `SRT_OFF_MODE_SEL + i)
                    mode_sel_reg[i] <= wdata;
                if (wr && addr == `SRT_OFF_SELF_SET + i)
                    self_set_reg[i] <= wdata;
                if (req_rise[i] && !s_mode)
                    armed_reg[i] <= 1'b1;
                // Clear ahead of the sequencer so an error raised in the same cycle wins
                if (wr && addr == `SRT_OFF_SELF_SET + i && wdata != self_set_reg[i])
                    sstat_hi_reg[i][1] <= 1'b0;
                case (state_reg[i])
                    ST_IDLE: begin
                        if (mode_rise && armed_reg[i]) begin
                            armed_reg[i] <= 1'b0;
                            state_reg[i] <= ST_AT;
                            tuning_active_lines[i] <= 1'b1;
                            pid_control[i] <= 1'b0;
                            if (mode_sel_reg[i] == `SRT_MODE_RISE_AT && !self_have_reg[i]
                                && s_pid[i] && stable_ok_reg[i] && s_rng[i] && s_lim[i]) begin
                                rise_ok_reg[i] <= 1'b1;
                            end else begin
                                rise_ok_reg[i] <= 1'b0;
                                if (mode_sel_reg[i] == `SRT_MODE_RISE_AT && !self_have_reg[i])
                                    tstat_reg[i][`SRT_TS_DIS] <= 1'b1;
                            end
                            // a running self-tuning is cancelled without result
                        // Self-tuning waits for operation mode and a rise-producing setting
                        end else if (s_mode && (self_set_reg[i] == `SRT_SELF_RISE
                                     || self_set_reg[i] == `SRT_SELF_BOTH)
                                     && !self_have_reg[i]) begin
                            if (s_sok[i]) begin
                                state_reg[i] <= ST_SELF;
                                tuning_active_lines[i] <= 1'b1;
                            end else if (s_sbad[i]) begin
                                sstat_hi_reg[i][0] <= 1'b1;
                                ev_reg[i] <= 1'b1;
                            end
                        end
                    end
                    ST_AT: begin
                        // Range loss only aborts a run that is computing the rise parameter
                        if (s_rng[i] == 1'b0 && rise_ok_reg[i]) begin
                            state_reg[i] <= ST_IDLE;
                            tuning_active_lines[i] <= 1'b0;
                            pid_control[i] <= 1'b1;
                            ev_reg[i] <= 1'b1;
                        end else if (s_fail[i] && rise_ok_reg[i]) begin
                            tstat_reg[i][`SRT_TS_ERR] <= 1'b1;
                            rise_ok_reg[i] <= 1'b0;
                        end else if (s_done[i]) begin
                            state_reg[i] <= ST_IDLE;
                            tuning_active_lines[i] <= 1'b0;
                            pid_control[i] <= 1'b1;
                            ev_reg[i] <= 1'b1;
                            if (rise_ok_reg[i]) begin
                                rise_store[i] <= 1'b1;
                                tstat_reg[i][`SRT_TS_DONE] <= 1'b1;
                            end
                        end
                    end
                    ST_SELF: begin
                        // A start sequence during self-tuning drops its result, tunes PID only
                        if (mode_rise && armed_reg[i]) begin
                            armed_reg[i] <= 1'b0;
                            state_reg[i] <= ST_AT;
                            rise_ok_reg[i] <= 1'b0;
                            pid_control[i] <= 1'b0;
                        end else if (s_sab[i]) begin
                            state_reg[i] <= ST_IDLE;
                            tuning_active_lines[i] <= 1'b0;
                            ev_reg[i] <= 1'b1;
                        end else if (s_fail[i]) begin
                            state_reg[i] <= ST_IDLE;
                            tuning_active_lines[i] <= 1'b0;
                            sstat_hi_reg[i][1] <= 1'b1;
                            ev_reg[i] <= 1'b1;
                        end else if (s_done[i]) begin
                            state_reg[i] <= ST_IDLE;
                            tuning_active_lines[i] <= 1'b0;
                            pid_control[i] <= 1'b1;
                            rise_store[i] <= 1'b1;
                            sstat_reg[i][1] <= 1'b1;
                            self_have_reg[i] <= 1'b1;
                            ev_reg[i] <= 1'b1;
                        end
                    end
                    default: state_reg[i] <= ST_IDLE;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Interrupt status: set wins over write-one-to-clear
    // irq is registered, so it trails a status change by one cycle
    always @(posedge clk) begin
        if (rst) begin
            irq_stat_reg <= 4'h0;
            irq_mask_reg <= 4'h0;
            irq <= 1'b0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~(irq_clr ? wdata[3:0] : 4'h0)) | ev_reg;
            if (wr && addr == `SRT_OFF_IRQ_MASK)
                irq_mask_reg <= wdata[3:0];
            irq <= |(irq_stat_reg & irq_mask_reg);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read port: one cycle latency; one status word per channel holds both tuning and self status
    // rdata returns to zero when no read is pending, so stale words never linger
    always @(posedge clk) begin
        if (rst) begin
            rdata <= 16'h0;
        end else if (rd) begin
            case (addr)
                `SRT_OFF_IRQ_STAT: rdata <= {12'h0, irq_stat_reg};
                `SRT_OFF_IRQ_MASK: rdata <= {12'h0, irq_mask_reg};
                `SRT_OFF_LINES: rdata <= {11'h0, mode_status_line, tuning_active_lines};
                4'h4, 4'h5, 4'h6, 4'h7: rdata <= mode_sel_reg[addr[1:0]];
                4'h8, 4'h9, 4'ha, 4'hb: rdata <= self_set_reg[addr[1:0]];
                4'hc, 4'hd, 4'he, 4'hf: rdata <= {6'h0, sstat_hi_reg[addr[1:0]], 5'h0,
                    tstat_reg[addr[1:0]][2], sstat_reg[addr[1:0]][1] |
                    tstat_reg[addr[1:0]][1], tstat_reg[addr[1:0]][0]};
                default: rdata <= 16'h0;
            endcase
        end else begin
            rdata <= 16'h0;
        end
    end
endmodule

// [hw/srt_defs.vh]
// Purpose: constants for the rise-parameter tuning sequencer
// Assumes: 200 MHz clk, synchronous active-high reset
// Notes: offsets are word indices on the plain register port
//
// Behaviour
// - After start sequence, tuning-active goes high and auto-tuning runs.
// - Successful rise result stored, tuning status bit 0 set.
// - Auto-tuning end drops tuning-active and returns to PID control.
// - Rise computed only if PID nonzero, value stable two minutes, in range, limiter zero.
// - Conditions unmet: only PID constants, status bit 2 set, tuning stays active.
// - Value leaving range after start ends auto-tuning as failed; the code ends it only while the rise parameter is being computed.
// - No gradient or short saturation during auto-tuning sets status bit 1.
// - Self-tuning start raises tuning-active and computes the rise parameter.
// - Self-tuning success stores value, sets bit 1, drops active, resumes PID.
// - Self-tuning unable to start sets self status bit 8.
// - Self-tuning gradient or saturation failure sets self status bit 9.
// - Abnormal self-tuning end stops the rise calculation.
// - Auto-tuning before self-tuned result: no rise result, only PID constants.
// - Auto-tuning after self-tuned result keeps that value, updates PID only.
`ifndef SRT_DEFS_VH
`define SRT_DEFS_VH
`define SRT_ADDR_W 4
`define SRT_OFF_CTRL 4'h0
`define SRT_OFF_IRQ_STAT 4'h1
`define SRT_OFF_IRQ_MASK 4'h2
`define SRT_OFF_LINES 4'h3
`define SRT_OFF_MODE_SEL 4'h4
`define SRT_OFF_SELF_SET 4'h8
`define SRT_OFF_TUNE_STAT 4'hc
`define SRT_OFF_SELF_STAT 4'hc
`define SRT_TS_DONE 0
`define SRT_TS_ERR 1
`define SRT_TS_DIS 2
`define SRT_SS_DONE 1
`define SRT_SS_DIS 8
`define SRT_SS_ERR 9
`define SRT_MODE_RISE_AT 16'h0001
`define SRT_SELF_RISE 16'h0002
`define SRT_SELF_BOTH 16'h0003
`define SRT_STABLE_S 120
`define SRT_CLK_HZ 200000000
`define SRT_STABLE_CYC 36'd24000000000
`endif

// [bench/srt_host_model.sv]
// Purpose: host side of the tuning start sequence
// Assumes: setting high drops every request line
// Notes: mode request rises four cycles after a tuning request, so the sync sees the order
`timescale 1ns/1ps
module srt_host_model (
    // Clock and control
    input wire clk,
    input wire setting,
    input wire [3:0] start,
    // Host lines
    output reg mode_request_line = 1'b0,
    output reg [3:0] tuning_request_lines = 4'h0
);
reg [3:0] start_reg = 4'h0;
reg [2:0] cnt_reg = 3'h0;
always @(posedge clk) begin
    start_reg <= start;
    if (setting) begin
        mode_request_line <= 1'b0;
        tuning_request_lines <= 4'h0;
        cnt_reg <= 3'h0;
    end else if (|(start & ~start_reg)) begin
        tuning_request_lines <= tuning_request_lines | (start & ~start_reg);
        cnt_reg <= 3'h4;
    end else if (cnt_reg != 3'h0) begin
        cnt_reg <= cnt_reg - 3'h1;
        if (cnt_reg == 3'h1) begin
            mode_request_line <= 1'b1;
        end
    end
end
endmodule

// [bench/srt_tuning_asserts.sv]
// Purpose: port checks for srt_tuning
// Assumes: loop outcome pins are held four cycles
// Notes: channel 0 carries the auto-tuning timing checks
`timescale 1ns/1ps
module srt_chk (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Host lines
    input wire mode_request_line,
    input wire mode_status_line,
    input wire [3:0] tuning_active_lines,
    // Loop side
    input wire [3:0] tune_done,
    input wire [3:0] process_value_in_range,
    input wire [3:0] pid_control,
    input wire [3:0] rise_store
);
default clocking @(posedge clk); endclocking
default disable iff (rst);
property p_store_pulse; (rise_store & $past(rise_store)) == 4'h0; endproperty
a_store_pulse: assert property (p_store_pulse) else $error("store pulse too long");
property p_store_cause;
    (rise_store & ~($past(tune_done) | $past(tune_done, 2) | $past(tune_done, 3))) == 4'h0;
endproperty
a_store_cause: assert property (p_store_cause) else $error("store without end");
property p_mode_follow; $rose(mode_status_line) |-> $past(mode_request_line); endproperty
a_mode_follow: assert property (p_mode_follow) else $error("mode status early");
property p_active_mode; $rose(tuning_active_lines[0]) |-> mode_status_line; endproperty
a_active_mode: assert property (p_active_mode) else $error("tuning outside run");
property p_st_active; $rose(tuning_active_lines[3]) |-> mode_status_line; endproperty
a_st_active: assert property (p_st_active) else $error("self tuning outside run");
property p_done_drop;
    tune_done[0] && tuning_active_lines[0] |-> ##[1:6] !tuning_active_lines[0];
endproperty
a_done_drop: assert property (p_done_drop) else $error("active stuck after end");
property p_end_pid;
    $fell(tuning_active_lines[0]) && process_value_in_range[0] |-> ##[0:2] pid_control[0];
endproperty
a_end_pid: assert property (p_end_pid) else $error("no return to pid");
property p_range_abort;
    tuning_active_lines[0] && !process_value_in_range[0] |-> ##[1:8] !tuning_active_lines[0];
endproperty
a_range_abort: assert property (p_range_abort) else $error("range loss ignored");
endmodule
bind srt_tuning srt_chk u_chk (.clk(clk), .rst(rst), .mode_request_line(mode_request_line),
    .mode_status_line(mode_status_line), .tuning_active_lines(tuning_active_lines),
    .tune_done(tune_done), .process_value_in_range(process_value_in_range),
    .pid_control(pid_control), .rise_store(rise_store));

// [bench/tb_top.sv]
// Purpose: directed bench for srt_tuning
// Assumes: stable time shortened to 10 cycles
// Notes: self abort and self error are exercised on channel 1
`timescale 1ns/1ps
module tb_top;
reg clk = 1'b0;
reg rst = 1'b1;
reg [3:0] addr = 4'h0;
reg [15:0] wdata = 16'h0000;
reg wr = 1'b0;
reg rd = 1'b0;
reg setting = 1'b1;
reg [3:0] start = 4'h0, pid_nz = 4'hf, in_rng = 4'hf, stable = 4'hf, lim0 = 4'hf;
reg [3:0] done = 4'h0, fail = 4'h0, st_ok = 4'h0, st_bad = 4'h0;
reg [3:0] abort = 4'h0;
wire mreq, mst, irq;
wire [3:0] treq, act, pid, store;
wire [15:0] rdata;
integer mismatches = 0, comparisons = 0;
srt_host_model host (.clk(clk), .setting(setting), .start(start),
    .mode_request_line(mreq), .tuning_request_lines(treq));
srt_tuning #(.STABLE_CYC(10)) uut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .mode_request_line(mreq), .tuning_request_lines(treq),
    .mode_status_line(mst), .tuning_active_lines(act), .pid_nonzero(pid_nz),
    .process_value_in_range(in_rng), .process_value_stable(stable), .output_limit_zero(lim0),
    .tune_done(done), .calc_fail(fail), .self_start_ok(st_ok), .self_start_bad(st_bad),
    .self_abort(abort), .pid_control(pid), .rise_store(store), .irq(irq));
initial forever #2.5 clk = ~clk;
////////////////////////////////////////////////////////////////
task test_done;
    begin
        $display("counts: %0d mismatches, %0d comparisons", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    end
endtask
task chk(input [15:0] got, input [15:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    end
endtask
task wr_reg(input [3:0] a, input [15:0] d);
    begin
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    end
endtask
task rd_chk(input [3:0] a, input [15:0] exp);
    begin
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    end
endtask
// Bounded wait on one tuning-active line; a hang ends the run
task wait_act(input [1:0] ch, input v);
    integer n;
    begin
        n = 0;
        while (act[ch] !== v && n < 400) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        if (n == 400) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: tuning line stuck", $time);
            test_done;
        end
    end
endtask
task arm(input [1:0] ch, input [3:0] pnz);
    begin
        @(posedge clk);
        setting <= 1'b1;
        pid_nz <= pnz;
        repeat (8) @(posedge clk);
        wr_reg(4'h4 + {2'b00, ch}, 16'h0001);
        setting <= 1'b0;
        start <= 4'h1 << ch;
        wait_act(ch, 1'b1);
    end
endtask
task finish_at(input [1:0] ch, input [3:0] fl);
    begin
        @(posedge clk);
        done <= 4'h1 << ch;
        fail <= fl;
        repeat (4) @(posedge clk);
        done <= 4'h0;
        fail <= 4'h0;
        start <= 4'h0;
        wait_act(ch, 1'b0);
    end
endtask
////////////////////////////////////////////////////////////////
initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk({12'h000, pid}, 16'h000f);
    rd_chk(4'h3, 16'h0000);
    wr_reg(4'h2, 16'h000f);
    rd_chk(4'h2, 16'h000f);
    arm(2'd0, 4'hf);
    finish_at(2'd0, 4'h0);
    chk({15'h0000, pid[0]}, 16'h0001);
    rd_chk(4'hc, 16'h0001);
    rd_chk(4'h1, 16'h0001);
    wr_reg(4'h1, 16'h0001);
    rd_chk(4'h1, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
    wr_reg(4'h7, 16'h0001);
    rd_chk(4'h7, 16'h0000);
    $display("test auto-tune done");
    arm(2'd1, 4'hd);
    finish_at(2'd1, 4'h0);
    rd_chk(4'hd, 16'h0004);
    arm(2'd2, 4'hf);
    finish_at(2'd2, 4'h4);
    rd_chk(4'he, 16'h0002);
    $display("test disable and error done");
    arm(2'd0, 4'hf);
    @(posedge clk);
    in_rng <= 4'he;
    wait_act(2'd0, 1'b0);
    @(posedge clk);
    in_rng <= 4'hf;
    start <= 4'h0;
    $display("test range abort done");
    wr_reg(4'hb, 16'h0002);
    st_ok <= 4'h8;
    wait_act(2'd3, 1'b1);
    @(posedge clk);
    st_ok <= 4'h0;
    finish_at(2'd3, 4'h0);
    rd_chk(4'hf, 16'h0002);
    wr_reg(4'ha, 16'h0003);
    st_bad <= 4'h4;
    repeat (4) @(posedge clk);
    st_bad <= 4'h0;
    repeat (4) @(posedge clk);
    rd_chk(4'he, 16'h0102);
    $display("test self-tuning done");
    arm(2'd3, 4'hf);
    finish_at(2'd3, 4'h0);
    rd_chk(4'hf, 16'h0002);
    wr_reg(4'h9, 16'h0003);
    st_ok <= 4'h2;
    wait_act(2'd1, 1'b1);
    rd_chk(4'h3, 16'h0012);
    st_ok <= 4'h0;
    abort <= 4'h2;
    wait_act(2'd1, 1'b0);
    @(posedge clk);
    abort <= 4'h0;
    st_ok <= 4'h2;
    wait_act(2'd1, 1'b1);
    @(posedge clk);
    st_ok <= 4'h0;
    fail <= 4'h2;
    wait_act(2'd1, 1'b0);
    @(posedge clk);
    fail <= 4'h0;
    rd_chk(4'hd, 16'h0204);
    chk({15'h0000, irq}, 16'h0001);
    $display("test abort and self error done");
    test_done;
end
endmodule
